// ==== rtl/gigabit_phy_mgmt_registers.sv ====
`timescale 1ns/10ps
`include "phy_mgmt_defs.svh"
module gigabit_phy_mgmt_registers
    import phy_mgmt_pkg::*;
#(
    parameter logic [4:0] PHY_ADDRESS = 5'h01
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       mdc,
    input  wire logic       mdio_in,
    output logic            mdio_out,
    output logic            mdio_oe,
    input  wire logic       rx_skew_strap,
    input  wire logic       tx_skew_strap,
    input  wire logic       soft_reset,
    input  wire logic       lp_1000_half,
    input  wire logic       lp_1000_full,
    input  wire logic       remote_rx_ok,
    input  wire logic       local_rx_ok,
    input  wire logic       resolved_master,
    input  wire logic       ms_fault_event,
    input  wire logic       idle_error_event,
    output logic            adv_1000_half,
    output logic            adv_1000_full,
    output logic            port_type_multi,
    output logic            manual_ms_enable,
    output logic            forced_master,
    output logic [2:0]      test_mode,
    output logic            rx_clock_skew_select,
    output logic            tx_clock_skew_select
);
    pin_sample_if smp ();

    pin_sampler u_sampler (
        .clock         (clock),
        .rst           (rst),
        .mdc           (mdc),
        .mdio_in       (mdio_in),
        .rx_skew_strap (rx_skew_strap),
        .tx_skew_strap (tx_skew_strap),
        .smp           (smp)
    );

    frame_state_t state_q;
    logic [5:0]   ones_q;
    logic [4:0]   cnt_q;
    logic [15:0]  shift_q;
    logic [1:0]   op_q;
    logic [9:0]   addr_q;
    logic [15:0]  rdata_q;
    logic         hit_q;
    logic         cfg_value_q;
    logic [7:0]   idle_count_q;
    logic         lp_half_q;
    logic         lp_full_q;
    logic         remote_ok_q;
    logic         local_ok_q;
    logic         master_q;
    logic         fault_q;
    logic [1:0]   strap_wait_q;
    logic         wr_pulse;
    logic         rd_pulse;
    logic [4:0]   frame_reg;
    logic         frame_hit;
    logic [15:0]  wdata;

    function automatic logic [15:0] read_word(input logic [4:0] regad);
        logic [15:0] w;
        w = 16'h0000;
        unique case (regad)
            `REG_GIGABIT_CONTROL:
                w = {test_mode, manual_ms_enable, cfg_value_q, port_type_multi,
                     adv_1000_full, adv_1000_half, `GC_LOW_RESERVED};
            `REG_GIGABIT_STATUS:
                w = {fault_q, master_q, local_ok_q, remote_ok_q, lp_full_q, lp_half_q,
                     `GS_RESERVED_BITS, idle_count_q};
            `REG_EXTENDED_ABILITY:
                w = {`EA_X_ABILITY, `EA_T_ABILITY, `EA_RESERVED};
            `REG_PHY_SPECIFIC_CONTROL:
                w = {`PS_RESERVED, tx_clock_skew_select, rx_clock_skew_select};
            default:
                w = 16'h0000;
        endcase
        return w;
    endfunction

    assign frame_reg = {addr_q[3:0], smp.mdio_bit};
    assign frame_hit = ({addr_q[8:4]} == PHY_ADDRESS);
    assign wdata     = {shift_q[14:0], smp.mdio_bit};
    assign rd_pulse  = smp.mdc_rise && state_q == F_ADDRESS && cnt_q == `MF_ADDR_BITS
                       && op_q == `MF_OP_READ && frame_hit;
    assign wr_pulse  = smp.mdc_rise && state_q == F_DATA && cnt_q == `MF_DATA_BITS
                       && op_q == `MF_OP_WRITE && hit_q;

    // management frame sequencing
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= F_PREAMBLE;
            ones_q  <= 6'h00;
            cnt_q   <= 5'h00;
            shift_q <= 16'h0000;
            op_q    <= 2'h0;
            addr_q  <= 10'h000;
            hit_q   <= 1'b0;
            rdata_q <= 16'h0000;
        end else if (smp.mdc_rise) begin
            unique case (state_q)
                F_PREAMBLE: begin
                    if (smp.mdio_bit) begin
                        if (ones_q != `MF_PREAMBLE_ONES) begin
                            ones_q <= ones_q + 6'h01;
                        end
                    end else if (ones_q == `MF_PREAMBLE_ONES) begin
                        state_q <= F_START;
                    end else begin
                        ones_q <= 6'h00;
                    end
                end
                F_START: begin
                    ones_q <= 6'h00;
                    cnt_q  <= 5'h00;
                    state_q <= smp.mdio_bit ? F_OPCODE : F_PREAMBLE;
                end
                F_OPCODE: begin
                    op_q  <= {op_q[0], smp.mdio_bit};
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == `MF_OP_BITS) begin
                        cnt_q   <= 5'h00;
                        state_q <= ({op_q[0], smp.mdio_bit} == `MF_OP_READ ||
                                    {op_q[0], smp.mdio_bit} == `MF_OP_WRITE)
                                   ? F_ADDRESS : F_PREAMBLE;
                    end
                end
                F_ADDRESS: begin
                    addr_q <= {addr_q[8:0], smp.mdio_bit};
                    cnt_q  <= cnt_q + 5'h01;
                    if (cnt_q == `MF_ADDR_BITS) begin
                        cnt_q   <= 5'h00;
                        hit_q   <= frame_hit;
                        rdata_q <= read_word(frame_reg);
                        state_q <= F_TURNAROUND;
                    end
                end
                F_TURNAROUND: begin
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == `MF_TA_BITS) begin
                        cnt_q   <= 5'h00;
                        shift_q <= rdata_q;
                        state_q <= F_DATA;
                    end
                end
                F_DATA: begin
                    shift_q <= wdata;
                    cnt_q   <= cnt_q + 5'h01;
                    if (cnt_q == `MF_DATA_BITS) begin
                        cnt_q   <= 5'h00;
                        state_q <= F_PREAMBLE;
                    end
                end
            endcase
        end
    end

    // serial data pin drive for reads
    always_ff @(posedge clock) begin
        if (rst) begin
            mdio_out <= 1'b0;
            mdio_oe  <= 1'b0;
        end else if (smp.mdc_rise && hit_q && op_q == `MF_OP_READ) begin
            if (state_q == F_TURNAROUND && cnt_q == 5'h00) begin
                mdio_oe  <= 1'b1;
                mdio_out <= `MF_TA_DRIVE;
            end else if (state_q == F_TURNAROUND) begin
                mdio_out <= rdata_q[15];
            end else if (state_q == F_DATA && cnt_q != `MF_DATA_BITS) begin
                mdio_out <= shift_q[14];
            end else if (state_q == F_DATA) begin
                mdio_oe  <= 1'b0;
                mdio_out <= 1'b0;
            end
        end
    end

    // gigabit control word
    always_ff @(posedge clock) begin
        if (rst) begin
            adv_1000_half    <= `GC_ADV_HW_RESET;
            adv_1000_full    <= `GC_ADV_HW_RESET;
            port_type_multi  <= `GC_PORT_HW_RESET;
            cfg_value_q      <= `GC_CFG_RESET;
            manual_ms_enable <= `GC_MANUAL_RESET;
            test_mode        <= `GC_TEST_RESET;
        end else if (soft_reset) begin
            adv_1000_half    <= `GC_ADV_SW_RESET;
            adv_1000_full    <= `GC_ADV_SW_RESET;
            port_type_multi  <= `GC_PORT_SW_RESET;
            cfg_value_q      <= `GC_CFG_RESET;
            manual_ms_enable <= `GC_MANUAL_RESET;
            test_mode        <= `GC_TEST_RESET;
        end else if (wr_pulse && addr_q[4:0] == `REG_GIGABIT_CONTROL) begin
            adv_1000_half    <= wdata[`GC_ADV_HD_BIT];
            adv_1000_full    <= wdata[`GC_ADV_FD_BIT];
            port_type_multi  <= wdata[`GC_PORT_TYPE_BIT];
            cfg_value_q      <= wdata[`GC_CFG_VALUE_BIT];
            manual_ms_enable <= wdata[`GC_MANUAL_EN_BIT];
            test_mode        <= wdata[`GC_TEST_MSB:`GC_TEST_LSB];
        end
    end

    // forced role only while manual configuration is on
    always_ff @(posedge clock) begin
        if (rst) begin
            forced_master <= 1'b0;
        end else begin
            forced_master <= manual_ms_enable & cfg_value_q;
        end
    end

    // idle error count, saturating, cleared when the status word is read
    always_ff @(posedge clock) begin
        if (rst || soft_reset) begin
            idle_count_q <= `IDLE_COUNT_RESET;
        end else if (rd_pulse && frame_reg == `REG_GIGABIT_STATUS) begin
            idle_count_q <= idle_error_event ? `IDLE_COUNT_ONE : `IDLE_COUNT_RESET;
        end else if (idle_error_event && idle_count_q != `IDLE_COUNT_MAX) begin
            idle_count_q <= idle_count_q + `IDLE_COUNT_ONE;
        end
    end

    // live status bits
    always_ff @(posedge clock) begin
        if (rst || soft_reset) begin
            lp_half_q   <= 1'b0;
            lp_full_q   <= 1'b0;
            remote_ok_q <= 1'b0;
            local_ok_q  <= 1'b0;
            master_q    <= 1'b0;
        end else begin
            lp_half_q   <= lp_1000_half;
            lp_full_q   <= lp_1000_full;
            remote_ok_q <= remote_rx_ok;
            local_ok_q  <= local_rx_ok;
            master_q    <= resolved_master;
        end
    end

    // configuration fault, self-clearing on read, new fault wins
    always_ff @(posedge clock) begin
        if (rst || soft_reset) begin
            fault_q <= 1'b0;
        end else if (ms_fault_event) begin
            fault_q <= 1'b1;
        end else if (rd_pulse && frame_reg == `REG_GIGABIT_STATUS) begin
            fault_q <= 1'b0;
        end
    end

    // skew selects: straps taken after reset release, untouched by software reset
    always_ff @(posedge clock) begin
        if (rst) begin
            strap_wait_q         <= 2'h0;
            rx_clock_skew_select <= 1'b0;
            tx_clock_skew_select <= 1'b0;
        end else if (strap_wait_q != `STRAP_SETTLE) begin
            strap_wait_q <= strap_wait_q + 2'h1;
            if (strap_wait_q + 2'h1 == `STRAP_SETTLE) begin
                rx_clock_skew_select <= smp.rx_strap;
                tx_clock_skew_select <= smp.tx_strap;
            end
        end else if (wr_pulse && addr_q[4:0] == `REG_PHY_SPECIFIC_CONTROL) begin
            rx_clock_skew_select <= wdata[`PS_RX_SKEW_BIT];
            tx_clock_skew_select <= wdata[`PS_TX_SKEW_BIT];
        end
    end
endmodule

// ==== pkg/phy_mgmt_defs.svh ====
`ifndef PHY_MGMT_DEFS_SVH
`define PHY_MGMT_DEFS_SVH

// register addresses on the management link
`define REG_GIGABIT_CONTROL      5'h09
`define REG_GIGABIT_STATUS       5'h0A
`define REG_EXTENDED_ABILITY     5'h0F
`define REG_PHY_SPECIFIC_CONTROL 5'h10

// gigabit control word fields
`define GC_ADV_HD_BIT            8
`define GC_ADV_FD_BIT            9
`define GC_PORT_TYPE_BIT         10
`define GC_CFG_VALUE_BIT         11
`define GC_MANUAL_EN_BIT         12
`define GC_TEST_LSB              13
`define GC_TEST_MSB              15
`define GC_LOW_RESERVED          8'h00

// gigabit control reset values: hardware and software
`define GC_ADV_HW_RESET          1'h1
`define GC_ADV_SW_RESET          1'h0
`define GC_PORT_HW_RESET         1'h1
`define GC_PORT_SW_RESET         1'h0
`define GC_CFG_RESET             1'h0
`define GC_MANUAL_RESET          1'h0
`define GC_TEST_RESET            3'h0

// gigabit status word fields
`define IDLE_COUNT_RESET         8'h00
`define IDLE_COUNT_ONE           8'h01
`define IDLE_COUNT_MAX           8'hFF
`define GS_RESERVED_BITS         2'h0

// extended ability word: 1000-T half/full able, 1000-X not able
`define EA_T_ABILITY             2'h3
`define EA_X_ABILITY             2'h0
`define EA_RESERVED              12'h000

// phy specific control: skew selects
`define PS_RX_SKEW_BIT           0
`define PS_TX_SKEW_BIT           1
`define PS_RESERVED              14'h0000

// management frame
`define MF_PREAMBLE_ONES         6'h20
`define MF_OP_READ               2'h2
`define MF_OP_WRITE              2'h1
`define MF_OP_BITS               5'h01
`define MF_ADDR_BITS             5'h09
`define MF_TA_BITS               5'h01
`define MF_DATA_BITS             5'h0F
`define MF_TA_DRIVE              1'h0

// cycles after reset release before straps are taken
`define STRAP_SETTLE             2'h3

`endif

// ==== pkg/phy_mgmt_pkg.sv ====
package phy_mgmt_pkg;

    typedef enum logic [2:0] {
        F_PREAMBLE,
        F_START,
        F_OPCODE,
        F_ADDRESS,
        F_TURNAROUND,
        F_DATA
    } frame_state_t;

endpackage

// ==== pkg/pin_sample_if.sv ====
`timescale 1ns/10ps
interface pin_sample_if;
    logic mdc_rise;
    logic mdio_bit;
    logic rx_strap;
    logic tx_strap;

    modport sampler (
        output mdc_rise,
        output mdio_bit,
        output rx_strap,
        output tx_strap
    );
    modport bank (
        input  mdc_rise,
        input  mdio_bit,
        input  rx_strap,
        input  tx_strap
    );
endinterface

// ==== rtl/pin_sampler.sv ====
`timescale 1ns/10ps
module pin_sampler #(
    parameter int PINS = 4
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       mdc,
    input  wire logic       mdio_in,
    input  wire logic       rx_skew_strap,
    input  wire logic       tx_skew_strap,
    pin_sample_if.sampler   smp
);
    logic [PINS-1:0] pins;
    logic [PINS-1:0] stage1_q;
    logic [PINS-1:0] stage2_q;
    logic            mdc_prev_q;

    assign pins = {tx_skew_strap, rx_skew_strap, mdio_in, mdc};

    // two-flop synchroniser per pin
    genvar i;
    generate
        for (i = 0; i < PINS; i++) begin : g_sync
            always_ff @(posedge clock) begin
                if (rst) begin
                    stage1_q[i] <= 1'b0;
                    stage2_q[i] <= 1'b0;
                end else begin
                    stage1_q[i] <= pins[i];
                    stage2_q[i] <= stage1_q[i];
                end
            end
        end
    endgenerate

    // rising edge of the management clock
    always_ff @(posedge clock) begin
        if (rst) begin
            mdc_prev_q <= 1'b0;
        end else begin
            mdc_prev_q <= stage2_q[0];
        end
    end

    assign smp.mdc_rise = stage2_q[0] & ~mdc_prev_q;
    assign smp.mdio_bit = stage2_q[1];
    assign smp.rx_strap = stage2_q[2];
    assign smp.tx_strap = stage2_q[3];
endmodule

// ==== bench/phy_mgmt_properties.sv ====
`timescale 1ns/10ps
module phy_mgmt_checker (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       rx_skew_strap,
    input wire logic       tx_skew_strap,
    input wire logic       soft_reset,
    input wire logic       mdio_out,
    input wire logic       mdio_oe,
    input wire logic       adv_1000_half,
    input wire logic       adv_1000_full,
    input wire logic       port_type_multi,
    input wire logic       manual_ms_enable,
    input wire logic       forced_master,
    input wire logic [2:0] test_mode,
    input wire logic       rx_clock_skew_select,
    input wire logic       tx_clock_skew_select
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    reset_values_a: assert property ($fell(rst) |-> adv_1000_half && adv_1000_full
        && port_type_multi && !manual_ms_enable && test_mode == 3'h0 && !mdio_oe
        && !rx_clock_skew_select && !tx_clock_skew_select)
        else $error("reset values wrong");
    strap_load_a: assert property ($fell(rst) |-> ##4
        rx_clock_skew_select == rx_skew_strap && tx_clock_skew_select == tx_skew_strap)
        else $error("strap default not taken");
    soft_clear_a: assert property (soft_reset |=> !adv_1000_half && !adv_1000_full
        && !port_type_multi && !manual_ms_enable && test_mode == 3'h0)
        else $error("soft reset did not clear control");
    soft_skew_a: assert property (soft_reset |=> $stable(rx_clock_skew_select)
        && $stable(tx_clock_skew_select))
        else $error("soft reset touched skew selects");
    forced_gate_a: assert property (forced_master |-> $past(manual_ms_enable))
        else $error("forced role without manual enable");
    adv_rise_a: assert property ($rose(adv_1000_half) || $rose(adv_1000_full)
        |-> !$past(soft_reset))
        else $error("advertise set through soft reset");
    ta_zero_a: assert property ($rose(mdio_oe) |-> !mdio_out)
        else $error("turnaround not driven low");
    oe_hold_a: assert property ($rose(mdio_oe) |-> mdio_oe [*8])
        else $error("read drive dropped early");
endmodule

bind gigabit_phy_mgmt_registers phy_mgmt_checker chk (
    .clock, .rst, .rx_skew_strap, .tx_skew_strap, .soft_reset, .mdio_out, .mdio_oe,
    .adv_1000_half, .adv_1000_full, .port_type_multi, .manual_ms_enable, .forced_master,
    .test_mode, .rx_clock_skew_select, .tx_clock_skew_select
);

// ==== bench/mgmt_station.sv ====
`timescale 1ns/10ps
module mgmt_station (
    input wire logic clock,
    input wire logic slow,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    output logic     mdc,
    output logic     mdio_in
);
    logic drive_en;
    logic drive_bit;

    initial begin
        mdc = 1'b0;
        drive_en = 1'b0;
        drive_bit = 1'b1;
    end

    // line level: device, host, else the pull-up
    assign mdio_in = mdio_oe ? mdio_out : (drive_en ? drive_bit : 1'b1);

    // one link clock period of 8 clocks; slow keeps the period but shortens the high phase
    task automatic bit_cycle(input logic en, input logic b, output logic s);
        int low;
        low = slow ? 6 : 4;
        @(posedge clock);
        mdc <= 1'b0;
        repeat (low / 2) @(posedge clock);
        drive_en <= en;
        drive_bit <= b;
        repeat (low - low / 2) @(posedge clock);
        mdc <= 1'b1;
        s = mdio_in;
        repeat (7 - low) @(posedge clock);
    endtask

    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [13:0] head;
        logic        s;
        logic        host;
        host = (op != 2'h2);
        head = {2'b01, op, phy, ra};
        for (int i = 0; i < 32; i++) bit_cycle(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) bit_cycle(1'b1, head[i], s);
        bit_cycle(host, 1'b1, s);
        bit_cycle(host, 1'b0, s);
        for (int i = 15; i >= 0; i--) begin
            bit_cycle(host, wd[i], s);
            rd[i] = s;
        end
        @(posedge clock);
        mdc <= 1'b0;
        drive_en <= 1'b0;
    endtask
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/10ps
`include "phy_mgmt_defs.svh"
module tb_top;
    localparam logic [4:0] PHY = 5'h05;
    logic       clock, rst, soft_reset, slow, mdc, mdio_in, mdio_out, mdio_oe;
    logic       rx_skew_strap, tx_skew_strap, ms_fault_event, idle_error_event;
    logic       lp_1000_half, lp_1000_full, remote_rx_ok, local_rx_ok, resolved_master;
    logic       adv_1000_half, adv_1000_full, port_type_multi, manual_ms_enable;
    logic       forced_master, rx_clock_skew_select, tx_clock_skew_select;
    logic [2:0] test_mode;
    int         mismatches, checked;

    gigabit_phy_mgmt_registers #(.PHY_ADDRESS(PHY)) dut (
        .clock, .rst, .mdc, .mdio_in, .mdio_out, .mdio_oe, .rx_skew_strap, .tx_skew_strap,
        .soft_reset, .lp_1000_half, .lp_1000_full, .remote_rx_ok, .local_rx_ok,
        .resolved_master, .ms_fault_event, .idle_error_event, .adv_1000_half,
        .adv_1000_full, .port_type_multi, .manual_ms_enable, .forced_master, .test_mode,
        .rx_clock_skew_select, .tx_clock_skew_select);
    mgmt_station sta (.clock, .slow, .mdio_out, .mdio_oe, .mdc, .mdio_in);

    always #25 clock = ~clock;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic rd(input logic [4:0] ra, output logic [15:0] d);
        sta.frame(`MF_OP_READ, PHY, ra, 16'h0000, d);
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        logic [15:0] unused;
        sta.frame(`MF_OP_WRITE, PHY, ra, d, unused);
        repeat (4) @(posedge clock);
    endtask
    task automatic pulses(input int n, input logic fault);
        repeat (n) begin
            @(posedge clock);
            idle_error_event <= !fault;
            ms_fault_event <= fault;
            @(posedge clock);
            idle_error_event <= 1'b0;
            ms_fault_event <= 1'b0;
        end
    endtask
    task automatic levels(input logic v);
        @(posedge clock);
        {lp_1000_half, lp_1000_full, remote_rx_ok, local_rx_ok, resolved_master} <= {5{v}};
        repeat (2) @(posedge clock);
    endtask
    function automatic logic [15:0] ctl_outs();
        return {8'h00, adv_1000_half, adv_1000_full, port_type_multi, manual_ms_enable,
                forced_master, test_mode};
    endfunction

    task automatic t_reset();
        logic [15:0] d;
        rd(`REG_GIGABIT_CONTROL, d);
        check(d, 16'h0700, "control reset");
        rd(`REG_GIGABIT_STATUS, d);
        check(d, 16'h0000, "status reset");
        rd(`REG_EXTENDED_ABILITY, d);
        check(d, 16'h3000, "ability reset");
        rd(`REG_PHY_SPECIFIC_CONTROL, d);
        check(d, 16'h0001, "skew straps");
        $display("test reset done");
    endtask

    task automatic t_control();
        logic [15:0] d;
        wr(`REG_GIGABIT_CONTROL, 16'hFFFF);
        rd(`REG_GIGABIT_CONTROL, d);
        check(d, 16'hFF00, "control readback");
        check(ctl_outs(), 16'h00FF, "control outputs");
        wr(`REG_GIGABIT_CONTROL, 16'h0800);
        check(ctl_outs(), 16'h0000, "value ignored when manual off");
        wr(`REG_GIGABIT_CONTROL, 16'h1000);
        check(ctl_outs(), 16'h0010, "manual slave");
        for (int i = 0; i < 8; i++) begin
            wr(`REG_GIGABIT_CONTROL, 16'(i) << 13);
            check(16'(test_mode), 16'(i), "test mode");
        end
        $display("test control done");
    endtask

    task automatic t_readonly();
        logic [15:0] d;
        wr(`REG_GIGABIT_STATUS, 16'hFFFF);
        wr(`REG_EXTENDED_ABILITY, 16'h0000);
        rd(`REG_GIGABIT_STATUS, d);
        check(d, 16'h0000, "status not writable");
        rd(`REG_EXTENDED_ABILITY, d);
        check(d, 16'h3000, "ability fixed");
        rd(5'h05, d);
        check(d, 16'h0000, "unmapped read");
        wr(`REG_PHY_SPECIFIC_CONTROL, 16'hFFFE);
        rd(`REG_PHY_SPECIFIC_CONTROL, d);
        check(d, 16'h0002, "skew write");
        check({14'h0, tx_clock_skew_select, rx_clock_skew_select}, 16'h0002, "skew pins");
        $display("test readonly done");
    endtask

    task automatic t_status();
        logic [15:0] d;
        levels(1'b1);
        pulses(3, 1'b0);
        pulses(1, 1'b1);
        rd(`REG_GIGABIT_STATUS, d);
        check(d, 16'hFC03, "status all set");
        rd(`REG_GIGABIT_STATUS, d);
        check(d, 16'h7C00, "fault and count cleared");
        levels(1'b0);
        pulses(260, 1'b0);
        rd(`REG_GIGABIT_STATUS, d);
        check(d, 16'h00FF, "count saturates");
        $display("test status done");
    endtask

    task automatic t_soft();
        logic [15:0] d;
        wr(`REG_GIGABIT_CONTROL, 16'hFF00);
        pulses(5, 1'b0);
        @(posedge clock);
        soft_reset <= 1'b1;
        @(posedge clock);
        soft_reset <= 1'b0;
        rd(`REG_GIGABIT_CONTROL, d);
        check(d, 16'h0000, "soft clears control");
        rd(`REG_GIGABIT_STATUS, d);
        check(d, 16'h0000, "soft clears count");
        rd(`REG_PHY_SPECIFIC_CONTROL, d);
        check(d, 16'h0002, "soft keeps skews");
        $display("test soft done");
    endtask

    task automatic t_link();
        logic [15:0] d;
        slow = 1'b1;
        rd(`REG_EXTENDED_ABILITY, d);
        check(d, 16'h3000, "slow link read");
        slow = 1'b0;
        sta.frame(`MF_OP_READ, PHY + 5'h01, `REG_EXTENDED_ABILITY, 16'h0000, d);
        check(d, 16'hFFFF, "other address not driven");
        sta.frame(`MF_OP_WRITE, PHY + 5'h01, `REG_GIGABIT_CONTROL, 16'hFFFF, d);
        rd(`REG_GIGABIT_CONTROL, d);
        check(d, 16'h0000, "other address not written");
        sta.frame(2'h3, PHY, `REG_GIGABIT_CONTROL, 16'hFFFF, d);
        rd(`REG_GIGABIT_CONTROL, d);
        check(d, 16'h0000, "unknown opcode not written");
        $display("test link done");
    endtask

    task automatic summarize();
        $display("checks %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clock);
        mismatches++;
        $display("[FAIL] %0t watchdog expired", $time);
        summarize();
    end

    initial begin
        clock = 1'b0;
        rst = 1'b1;
        soft_reset = 1'b0;
        slow = 1'b0;
        rx_skew_strap = 1'b1;
        tx_skew_strap = 1'b0;
        {ms_fault_event, idle_error_event} = 2'h0;
        {lp_1000_half, lp_1000_full, remote_rx_ok, local_rx_ok, resolved_master} = 5'h00;
        mismatches = 0;
        checked = 0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        repeat (6) @(posedge clock);
        t_reset();
        t_control();
        t_readonly();
        t_status();
        t_soft();
        t_link();
        summarize();
    end
endmodule
